// ---- hw/smt_regs.sv ----
// module: synthesizer and demodulator test/trim register bank
`timescale 1ns/1ps
`default_nettype none
module smt_regs (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [6:0] ADDR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  input wire logic [4:0] PUMP_CORR_AUTO,
  input wire logic [3:0] VCO_CORR_AUTO,
  input wire logic [6:0] CAL_RESULT,
  input wire logic CAL_DONE,
  input wire logic TX_ACTIVE,
  input wire logic CAL_BEFORE_TX,
  input wire logic IDLE_PLL_ON,
  output logic CAL_START,
  output logic BCR_COMP_BYPASS,
  output logic SLICER_COMP_BYPASS,
  output logic DITHER_BIPOLAR,
  output logic OSC_DETECT_RUN,
  output logic [3:0] OOK_THRESH_BITS,
  output logic REF_FROM_10MHZ,
  output logic REF_INVERT,
  output logic DISC_TOGGLE_EN,
  output logic PFD_RESET,
  output logic FB_DIV_RESET,
  output logic PUMP_FORCE_UP,
  output logic PUMP_FORCE_DOWN,
  output logic PUMP_DC_ONLY,
  output logic [2:0] PUMP_DC_CURR,
  output logic [1:0] PUMP_GAIN,
  output logic [4:0] PUMP_CORR,
  output logic FB_DIV_HICURR,
  output logic [1:0] DIV_THREE_TRIM,
  output logic [1:0] DIV_TWO_TRIM,
  output logic [1:0] DIV_ONEHALF_TRIM,
  output logic [3:0] VCO_CORR,
  output logic [1:0] VCO_CURR,
  output logic [6:0] VCO_CAL
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] demod;
    logic [7:0] pforce;
    logic [2:0] pgain_top;
    logic [4:0] pcorr_wr;
    logic [7:0] divtrim;
    logic [7:0] osctrim;
    logic cal_ov;
    logic [6:0] cal_wr;
    logic cal_req;
    logic [7:0] rdata;
    logic cal_start;
    logic [4:0] pump_corr;
    logic [3:0] vco_corr;
    logic [1:0] vco_curr;
    logic [6:0] vco_cal;
    logic osc_run;
    logic [3:0] ook_bits;
  } smt_state_t;

  smt_state_t st;
  smt_state_t next_st;
  logic boost_window;
  logic [6:0] pick_p;
  logic [4:0] eff_pcorr;
  logic [6:0] eff_cal;

  // correction, calibration mux: one selector used for both override fields
  function automatic logic [6:0] smt_pick(input logic ov, input logic [6:0] wr,
                                          input logic [6:0] auto_v);
    smt_pick = ov ? wr : auto_v;
  endfunction

  // ook threshold length decode, shared by reset and next-state logic
  function automatic logic [3:0] smt_ook_len(input logic long_sel);
    smt_ook_len = long_sel ? smt_pkg::OOK_LONG : smt_pkg::OOK_SHORT;
  endfunction

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    next_st = st;
    boost_window = TX_ACTIVE | CAL_BEFORE_TX;
    pick_p = smt_pick(st.pgain_top[0], {2'h0, st.pcorr_wr}, {2'h0, PUMP_CORR_AUTO});
    eff_pcorr = pick_p[4:0];
    eff_cal = smt_pick(st.cal_ov, st.cal_wr, CAL_RESULT);
    next_st.cal_start = 1'b0;
    // force-cal fires only in idle with the pll on; the bit then clears itself.
    // a host write in the same cycle re-arms it below: the set wins
    if (st.cal_req && IDLE_PLL_ON) begin
      next_st.cal_req = 1'b0;
      next_st.cal_start = 1'b1;
    end
    if (WR_EN) begin
      unique case (ADDR)
        smt_pkg::ADDR_DEMOD: next_st.demod = WDATA;
        smt_pkg::ADDR_PFORCE: next_st.pforce = WDATA;
        smt_pkg::ADDR_PGAIN: begin
          next_st.pgain_top = WDATA[7:5];
          next_st.pcorr_wr = WDATA[4:0];
        end
        smt_pkg::ADDR_DIVTRIM: next_st.divtrim = WDATA;
        smt_pkg::ADDR_OSCTRIM: next_st.osctrim = WDATA;
        smt_pkg::ADDR_OSCCAL: begin
          next_st.cal_ov = WDATA[smt_pkg::B_CALOV];
          next_st.cal_wr = WDATA[6:0];
        end
        smt_pkg::ADDR_CALCTRL: begin
          if (WDATA[smt_pkg::B_FORCECAL]) begin
            next_st.cal_req = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // read data is registered, valid the cycle after RD_EN
    if (RD_EN) begin
      unique case (ADDR)
        smt_pkg::ADDR_DEMOD: next_st.rdata = st.demod;
        smt_pkg::ADDR_PFORCE: next_st.rdata = st.pforce;
        smt_pkg::ADDR_PGAIN: next_st.rdata = {st.pgain_top, eff_pcorr};
        smt_pkg::ADDR_DIVTRIM: next_st.rdata = st.divtrim;
        smt_pkg::ADDR_OSCTRIM: next_st.rdata = st.osctrim;
        smt_pkg::ADDR_OSCCAL: next_st.rdata = {CAL_DONE, eff_cal};
        smt_pkg::ADDR_CALCTRL: next_st.rdata = {6'h00, st.cal_req, 1'b0};
        default: next_st.rdata = 8'h00;
      endcase
    end
    next_st.pump_corr = eff_pcorr;
    next_st.vco_cal = eff_cal;
    // decoded demod outputs get their own flops so the pins carry no gates
    next_st.osc_run = ~next_st.demod[smt_pkg::B_OSCDIS];
    next_st.ook_bits = smt_ook_len(next_st.demod[smt_pkg::B_OOKLEN]);
    // boost overrides win over manual trim during tx and cal ahead of tx
    if (st.divtrim[smt_pkg::B_BOOST] && boost_window) begin
      next_st.vco_corr = smt_pkg::VCORR_BOOST;
    end else if (st.osctrim[smt_pkg::B_VCOROV]) begin
      next_st.vco_corr = st.osctrim[5:2];
    end else begin
      next_st.vco_corr = VCO_CORR_AUTO;
    end
    if (st.osctrim[smt_pkg::B_BOOST] && boost_window) begin
      next_st.vco_curr = smt_pkg::VCUR_BOOST;
    end else begin
      next_st.vco_curr = st.osctrim[1:0];
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= '0;
      st.demod <= smt_pkg::RST_DEMOD;
      st.pforce <= smt_pkg::RST_PFORCE;
      st.pgain_top <= smt_pkg::RST_PGAIN_TOP;
      st.pcorr_wr <= smt_pkg::RST_PCORR;
      st.divtrim <= smt_pkg::RST_DIVTRIM;
      st.osctrim <= smt_pkg::RST_OSCTRIM;
      st.cal_wr <= smt_pkg::RST_OSCCAL;
      st.vco_curr <= smt_pkg::RST_OSCTRIM[1:0];
      st.osc_run <= ~smt_pkg::RST_DEMOD[smt_pkg::B_OSCDIS];
      st.ook_bits <= smt_ook_len(smt_pkg::RST_DEMOD[smt_pkg::B_OOKLEN]);
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs, all straight from state flops
  // ************************************************************
  assign RDATA = st.rdata;
  assign CAL_START = st.cal_start;
  assign BCR_COMP_BYPASS = st.demod[smt_pkg::B_BCRBYP];
  assign SLICER_COMP_BYPASS = st.demod[smt_pkg::B_SLCBYP];
  assign DITHER_BIPOLAR = st.demod[smt_pkg::B_DTTYPE];
  assign OSC_DETECT_RUN = st.osc_run;
  assign OOK_THRESH_BITS = st.ook_bits;
  assign REF_FROM_10MHZ = st.demod[smt_pkg::B_REFSEL];
  assign REF_INVERT = st.demod[smt_pkg::B_REFINV];
  assign DISC_TOGGLE_EN = st.demod[smt_pkg::B_DTOGG];
  assign PFD_RESET = st.pforce[smt_pkg::B_PFDRST];
  assign FB_DIV_RESET = st.pforce[smt_pkg::B_FBRST];
  assign PUMP_FORCE_UP = st.pforce[smt_pkg::B_FUP];
  assign PUMP_FORCE_DOWN = st.pforce[smt_pkg::B_FDN];
  assign PUMP_DC_ONLY = st.pforce[smt_pkg::B_DCONLY];
  assign PUMP_DC_CURR = st.pforce[2:0];
  assign PUMP_GAIN = st.pgain_top[2:1];
  assign PUMP_CORR = st.pump_corr;
  assign FB_DIV_HICURR = st.divtrim[smt_pkg::B_FBHC];
  assign DIV_THREE_TRIM = st.divtrim[5:4];
  assign DIV_TWO_TRIM = st.divtrim[3:2];
  assign DIV_ONEHALF_TRIM = st.divtrim[1:0];
  assign VCO_CORR = st.vco_corr;
  assign VCO_CURR = st.vco_curr;
  assign VCO_CAL = st.vco_cal;

  // ************************************************************
  // assertions
  // ************************************************************
  // the write checks are stated against the bus byte that caused them, so a wrong
  // slice in the output wiring shows up here rather than on the bench
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // demodulator test bits follow the written byte one cycle later
  AST_BCR_BYP: assert property (WR_EN && ADDR == smt_pkg::ADDR_DEMOD |=>
    BCR_COMP_BYPASS == $past(WDATA[smt_pkg::B_BCRBYP]))
    else $error("bcr bypass mismatch");
  AST_SLICER_BYP: assert property (WR_EN && ADDR == smt_pkg::ADDR_DEMOD |=>
    SLICER_COMP_BYPASS == $past(WDATA[smt_pkg::B_SLCBYP]))
    else $error("slicer bypass mismatch");
  AST_DITHER: assert property (WR_EN && ADDR == smt_pkg::ADDR_DEMOD |=>
    DITHER_BIPOLAR == $past(WDATA[smt_pkg::B_DTTYPE]))
    else $error("dither type mismatch");
  AST_OSC_RUN: assert property (WR_EN && ADDR == smt_pkg::ADDR_DEMOD |=>
    OSC_DETECT_RUN == !$past(WDATA[smt_pkg::B_OSCDIS]))
    else $error("oscillation detect enable wrong");
  AST_OOK: assert property (WR_EN && ADDR == smt_pkg::ADDR_DEMOD |=>
    OOK_THRESH_BITS == ($past(WDATA[smt_pkg::B_OOKLEN]) ? smt_pkg::OOK_LONG : smt_pkg::OOK_SHORT))
    else $error("ook length wrong");
  AST_REF_SEL: assert property (WR_EN && ADDR == smt_pkg::ADDR_DEMOD |=>
    REF_FROM_10MHZ == $past(WDATA[smt_pkg::B_REFSEL]))
    else $error("reference select mismatch");
  AST_REF_INV: assert property (WR_EN && ADDR == smt_pkg::ADDR_DEMOD |=>
    REF_INVERT == $past(WDATA[smt_pkg::B_REFINV]))
    else $error("reference inversion mismatch");
  AST_DISC_TOGGLE: assert property (WR_EN && ADDR == smt_pkg::ADDR_DEMOD |=>
    DISC_TOGGLE_EN == $past(WDATA[smt_pkg::B_DTOGG]))
    else $error("discriminator toggle mismatch");

  // charge pump controls
  AST_FORCE_UP: assert property (WR_EN && ADDR == smt_pkg::ADDR_PFORCE |=>
    PUMP_FORCE_UP == $past(WDATA[smt_pkg::B_FUP]))
    else $error("force up mismatch");
  AST_FORCE_DOWN: assert property (WR_EN && ADDR == smt_pkg::ADDR_PFORCE |=>
    PUMP_FORCE_DOWN == $past(WDATA[smt_pkg::B_FDN]))
    else $error("force down mismatch");
  AST_DC_FIELDS: assert property (WR_EN && ADDR == smt_pkg::ADDR_PFORCE |=>
    {PUMP_DC_ONLY, PUMP_DC_CURR} == $past(WDATA[3:0]))
    else $error("dc current fields mismatch");
  AST_PFD_RESET: assert property (WR_EN && ADDR == smt_pkg::ADDR_PFORCE |=>
    {PFD_RESET, FB_DIV_RESET} == $past(WDATA[7:6]))
    else $error("direct analog controls mismatch");
  AST_PUMP_GAIN: assert property (WR_EN && ADDR == smt_pkg::ADDR_PGAIN |=>
    PUMP_GAIN == $past(WDATA[7:6]))
    else $error("pump gain mismatch");
  AST_PCORR_OV: assert property (st.pgain_top[0] |=>
    PUMP_CORR == $past(st.pcorr_wr))
    else $error("override correction not applied");
  AST_PCORR_AUTO: assert property (!st.pgain_top[0] |=>
    PUMP_CORR == $past(PUMP_CORR_AUTO))
    else $error("pump correction not tracking");
  AST_PCORR_READ: assert property (RD_EN && ADDR == smt_pkg::ADDR_PGAIN |=>
    RDATA[4:0] == $past(st.pgain_top[0] ? st.pcorr_wr : PUMP_CORR_AUTO))
    else $error("pump correction read wrong");

  // oscillator and divider trims, boost wins inside the transmit window
  AST_VCORR_BOOST: assert property (st.divtrim[smt_pkg::B_BOOST] &&
    (TX_ACTIVE || CAL_BEFORE_TX) |=> VCO_CORR == smt_pkg::VCORR_BOOST)
    else $error("vco correction boost missing");
  AST_VCORR_OV: assert property (st.osctrim[smt_pkg::B_VCOROV] &&
    !(st.divtrim[smt_pkg::B_BOOST] && (TX_ACTIVE || CAL_BEFORE_TX)) |=>
    VCO_CORR == $past(st.osctrim[5:2]))
    else $error("vco correction override not applied");
  AST_VCUR_BOOST: assert property (st.osctrim[smt_pkg::B_BOOST] &&
    (TX_ACTIVE || CAL_BEFORE_TX) |=> VCO_CURR == smt_pkg::VCUR_BOOST)
    else $error("vco current boost missing");
  AST_VCUR_TRIM: assert property (!(st.osctrim[smt_pkg::B_BOOST] &&
    (TX_ACTIVE || CAL_BEFORE_TX)) |=> VCO_CURR == $past(st.osctrim[1:0]))
    else $error("vco current trim not applied");
  AST_FB_HICURR: assert property (WR_EN && ADDR == smt_pkg::ADDR_DIVTRIM |=>
    FB_DIV_HICURR == $past(WDATA[smt_pkg::B_FBHC]))
    else $error("feedback divider current mismatch");
  AST_DIV_TRIMS: assert property (WR_EN && ADDR == smt_pkg::ADDR_DIVTRIM |=>
    {DIV_THREE_TRIM, DIV_TWO_TRIM, DIV_ONEHALF_TRIM} == $past(WDATA[5:0]))
    else $error("divider trims mismatch");

  // calibration value, override and force
  AST_CAL_READ: assert property (RD_EN && ADDR == smt_pkg::ADDR_OSCCAL && !st.cal_ov |=>
    RDATA == {$past(CAL_DONE), $past(CAL_RESULT)})
    else $error("cal read wrong");
  AST_CAL_AUTO: assert property (!st.cal_ov |=>
    VCO_CAL == $past(CAL_RESULT))
    else $error("cal result not used");
  AST_CAL_OV: assert property (st.cal_ov |=>
    VCO_CAL == $past(st.cal_wr))
    else $error("cal override not used");
  AST_CAL_DONE_READ: assert property (RD_EN && ADDR == smt_pkg::ADDR_OSCCAL |=>
    RDATA[smt_pkg::B_CALOV] == $past(CAL_DONE))
    else $error("cal done read wrong");
  AST_CAL_START: assert property (st.cal_req && IDLE_PLL_ON |=>
    CAL_START)
    else $error("force cal did not start");
  AST_CAL_SELF_CLEAR: assert property (st.cal_req && IDLE_PLL_ON &&
    !(WR_EN && ADDR == smt_pkg::ADDR_CALCTRL && WDATA[smt_pkg::B_FORCECAL]) |=> !st.cal_req)
    else $error("force cal bit did not clear");
  AST_CAL_WAIT: assert property (!(st.cal_req && IDLE_PLL_ON) |=>
    !CAL_START)
    else $error("cal start without request");

  // holes in the map read as zero
  AST_UNMAPPED_READ: assert property (RD_EN &&
    (ADDR < smt_pkg::ADDR_CALCTRL || ADDR > smt_pkg::ADDR_OSCCAL) |=> RDATA == 8'h00)
    else $error("unmapped read not zero");

  // main scenarios
  COV_CAL: cover property (st.cal_req ##[1:20] CAL_START);
  COV_BOOST: cover property (st.divtrim[smt_pkg::B_BOOST] && TX_ACTIVE);
  COV_PCORR_OV: cover property (WR_EN && ADDR == smt_pkg::ADDR_PGAIN && WDATA[smt_pkg::B_CORROV]);
  COV_CAL_OV: cover property (WR_EN && ADDR == smt_pkg::ADDR_OSCCAL && WDATA[smt_pkg::B_CALOV]);
endmodule // smt_regs
`default_nettype wire

// ---- hw/smt_pkg.sv ----
// package: register map, field positions and reset values of the synth/modem test bank
package smt_pkg;
  // ************************************************************
  // register addresses on the serial register port
  // ************************************************************
  localparam logic [6:0] ADDR_DEMOD = 7'h56;
  localparam logic [6:0] ADDR_PFORCE = 7'h57;
  localparam logic [6:0] ADDR_PGAIN = 7'h58;
  localparam logic [6:0] ADDR_DIVTRIM = 7'h59;
  localparam logic [6:0] ADDR_OSCTRIM = 7'h5a;
  localparam logic [6:0] ADDR_OSCCAL = 7'h5b;
  localparam logic [6:0] ADDR_CALCTRL = 7'h55;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_DEMOD = 8'h00;
  localparam logic [7:0] RST_PFORCE = 8'h00;
  localparam logic [2:0] RST_PGAIN_TOP = 3'h4;
  localparam logic [4:0] RST_PCORR = 5'h00;
  localparam logic [7:0] RST_DIVTRIM = 8'h00;
  localparam logic [7:0] RST_OSCTRIM = 8'h03;
  localparam logic [6:0] RST_OSCCAL = 7'h00;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int B_BCRBYP = 7;
  localparam int B_SLCBYP = 6;
  localparam int B_DTTYPE = 5;
  localparam int B_OSCDIS = 4;
  localparam int B_OOKLEN = 3;
  localparam int B_REFSEL = 2;
  localparam int B_REFINV = 1;
  localparam int B_DTOGG = 0;
  localparam int B_PFDRST = 7;
  localparam int B_FBRST = 6;
  localparam int B_FUP = 5;
  localparam int B_FDN = 4;
  localparam int B_DCONLY = 3;
  localparam int B_CORROV = 5;
  localparam int B_BOOST = 7;
  localparam int B_FBHC = 6;
  localparam int B_VCOROV = 6;
  localparam int B_CALOV = 7;
  localparam int B_FORCECAL = 1;
  localparam logic [3:0] VCORR_BOOST = 4'hf;
  localparam logic [1:0] VCUR_BOOST = 2'h3;
  localparam logic [3:0] OOK_LONG = 4'h8;
  localparam logic [3:0] OOK_SHORT = 4'h4;
endpackage : smt_pkg

// ---- tb/smt_cal_model.sv ----
// partner model: calibration engine behind the test register bank
`timescale 1ns/1ps
`default_nettype none
module smt_cal_model #(
  parameter logic [6:0] CAL_VAL = 7'h2d
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CAL_START,
  output logic CAL_DONE,
  output logic [6:0] CAL_RESULT
);
  int busy;
  // a started run drops done for a fixed time
  always @(posedge CLK) begin
    if (RST) begin
      busy <= 0;
    end else if (CAL_START) begin
      busy <= 8;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end
  end
  // mid-run the result is stale, shown inverted so a wrong pick cannot pass
  assign CAL_DONE = (busy == 0);
  assign CAL_RESULT = (busy == 0) ? CAL_VAL : ~CAL_VAL;
endmodule // smt_cal_model
`default_nettype wire

// ---- tb/tb.sv ----
// testbench: test/trim register bank, writes and reads checked against the map
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [6:0] C_VAL = 7'h2d;
  logic clk, rst, wr_en, rd_en, tx, cbt, idle, cal_start, cal_done, rd_d;
  logic bcr, slc, dith, osc, rsel, rinv, disc, pfd, fbr, fup, fdn, dco, fbhc;
  logic [6:0] addr, cal_res, vco_cal;
  logic [7:0] wdata, rdata, r;
  logic [4:0] p_auto, pump_corr;
  logic [3:0] v_auto, ook, vco_corr;
  logic [2:0] dc_curr;
  logic [1:0] gain, t3, t2, t15, vco_curr;
  logic [15:0] got;
  logic [7:0] exp_q[$];
  int n_mismatch, checked, n_start, i;
  smt_regs u_dut (.CLK(clk), .RST(rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
    .WDATA(wdata), .RDATA(rdata), .PUMP_CORR_AUTO(p_auto), .VCO_CORR_AUTO(v_auto),
    .CAL_RESULT(cal_res), .CAL_DONE(cal_done), .TX_ACTIVE(tx), .CAL_BEFORE_TX(cbt),
    .IDLE_PLL_ON(idle), .CAL_START(cal_start), .BCR_COMP_BYPASS(bcr),
    .SLICER_COMP_BYPASS(slc), .DITHER_BIPOLAR(dith), .OSC_DETECT_RUN(osc),
    .OOK_THRESH_BITS(ook), .REF_FROM_10MHZ(rsel), .REF_INVERT(rinv), .DISC_TOGGLE_EN(disc),
    .PFD_RESET(pfd), .FB_DIV_RESET(fbr), .PUMP_FORCE_UP(fup), .PUMP_FORCE_DOWN(fdn),
    .PUMP_DC_ONLY(dco), .PUMP_DC_CURR(dc_curr), .PUMP_GAIN(gain), .PUMP_CORR(pump_corr),
    .FB_DIV_HICURR(fbhc), .DIV_THREE_TRIM(t3), .DIV_TWO_TRIM(t2), .DIV_ONEHALF_TRIM(t15),
    .VCO_CORR(vco_corr), .VCO_CURR(vco_curr), .VCO_CAL(vco_cal));
  smt_cal_model #(.CAL_VAL(C_VAL)) u_cal (.CLK(clk), .RST(rst), .CAL_START(cal_start),
    .CAL_DONE(cal_done), .CAL_RESULT(cal_res));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  // the note goes in before the strobe, so the watcher always finds it
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk);
    exp_q.push_back(e);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
  endtask
  // outputs behind a register lag it by one more flop, so allow three cycles
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // read data is valid the cycle after the strobe; count start pulses too
  always @(posedge clk) rd_d <= rd_en;
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      chk("read data", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
    if (cal_start === 1'b1) begin
      n_start++;
    end
  end
  initial begin
    rst = 1'b1;
    {wr_en, rd_en, tx, cbt, idle} = 5'h00;
    addr = 7'h00;
    wdata = 8'h00;
    void'($urandom(77));
    p_auto = 5'($urandom());
    v_auto = 4'($urandom());
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk("reset outputs", {9'h0, osc, ook, vco_curr}, 16'h0053);
    rd(7'h56, 8'h00);
    rd(7'h58, {3'h4, p_auto});
    rd(7'h5a, 8'h03);
    rd(7'h60, 8'h00);
    // walk a single one through the demodulator test register
    for (i = 0; i < 8; i++) begin
      r = 8'h01 << i;
      wr(7'h56, r);
      settle();
      got = {5'h0, bcr, slc, dith, osc, ook, rsel, rinv, disc};
      chk("demod", got, {5'h0, r[7:5], ~r[4], r[3] ? 4'h8 : 4'h4, r[2:0]});
      rd(7'h56, r);
    end
    r = 8'($urandom());
    wr(7'h57, r);
    wr(7'h59, r & 8'h7f);
    settle();
    chk("pump force", {8'h0, pfd, fbr, fup, fdn, dco, dc_curr}, {8'h0, r});
    chk("div trims", {9'h0, fbhc, t3, t2, t15}, {9'h0, r[6:0]});
    rd(7'h57, r);
    chk("pump auto", {11'h0, pump_corr}, {11'h0, p_auto});
    r = {3'h3, 5'($urandom())};
    wr(7'h58, r);
    settle();
    chk("pump override", {8'h0, gain, 1'b1, pump_corr}, {8'h0, r});
    rd(7'h58, r);
    // boost disabled: auto correction and programmed trim pass even in transmit
    wr(7'h59, 8'h00);
    wr(7'h5a, 8'h15);
    tx = 1'b1;
    settle();
    chk("vco no boost", {10'h0, vco_corr, vco_curr}, {10'h0, v_auto, 2'h1});
    wr(7'h59, 8'h80);
    wr(7'h5a, 8'hd5);
    settle();
    chk("vco boost tx", {10'h0, vco_corr, vco_curr}, 16'h003f);
    {tx, cbt} = 2'b01;
    settle();
    chk("vco boost cal", {10'h0, vco_corr, vco_curr}, 16'h003f);
    cbt = 1'b0;
    settle();
    chk("vco override", {10'h0, vco_corr, vco_curr}, 16'h0015);
    rd(7'h5b, {1'b1, C_VAL});
    r = 8'($urandom()) | 8'h80;
    wr(7'h5b, r);
    settle();
    chk("cal override", {9'h0, vco_cal}, {9'h0, r[6:0]});
    rd(7'h5b, r);
    wr(7'h5b, 8'h00);
    // forced calibration must wait for idle with the loop on, then self-clear
    wr(7'h55, 8'h02);
    rd(7'h55, 8'h02);
    repeat (8) @(negedge clk);
    chk("early start", 16'(n_start), 16'h0);
    idle = 1'b1;
    for (i = 0; i < 20 && n_start == 0; i++) @(negedge clk);
    if (n_start == 0) begin
      n_mismatch++;
      end_of_test();
    end
    rd(7'h5b, {1'b0, ~C_VAL});
    rd(7'h55, 8'h00);
    repeat (12) @(negedge clk);
    chk("one start", 16'(n_start), 16'h1);
    chk("cal auto", {9'h0, vco_cal}, {9'h0, C_VAL});
    rd(7'h5b, {1'b1, C_VAL});
    repeat (3) @(negedge clk);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
